// [tb/pss_i2c_host.sv]
// Host-side serial controller model that reaches the register bank
module pss_i2c_host import pss_pkg::*; (
  input wire logic clock,
  input wire logic sda_out,
  input wire logic sda_oe,
  output logic scl,
  output logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pull = 1'b0;
  // Open-drain data wire with pull-up: low while either side pulls
  assign sda_in = ~pull & (sda_oe ? sda_out : 1'b1);
  // Serial clock idles high and stands still between frames
  initial scl = 1'b1;
  // A quarter of the 320 ns serial period, kept on falling clock edges
  task automatic qtr();
    repeat (2) @(negedge clock);
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    pull = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    pull = 1'b1;
    qtr();
    scl = 1'b0;
    qtr();
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    pull = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    pull = 1'b0;
    qtr();
    qtr();
  endtask
  // One bit: data set while the clock is low, sampled mid high phase
  task automatic bitx(input logic b, output logic r);
    pull = ~b;
    qtr();
    scl = 1'b1;
    qtr();
    r = sda_in;
    qtr();
    scl = 1'b0;
    qtr();
  endtask
  // Eight bits most significant first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic r);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(last, r);
  endtask
  // Register write; ok when all three bytes were acknowledged
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
    logic [7:0] q;
    logic r0, r1, r2;
    start();
    xfer({dev, 1'b0}, 1'b1, q, r0);
    xfer(a, 1'b1, q, r1);
    xfer(d, 1'b1, q, r2);
    stop();
    ok = ~(r0 | r1 | r2);
  endtask
  // Register read through pointer write, repeated start and a final not-acknowledge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic r0, r1, r2, r3;
    start();
    xfer({BUS_ADDR_DEFAULT, 1'b0}, 1'b1, q, r0);
    xfer(a, 1'b1, q, r1);
    start();
    xfer({BUS_ADDR_DEFAULT, 1'b1}, 1'b1, q, r2);
    xfer(8'hff, 1'b1, d, r3);
    stop();
    ok = ~(r0 | r1 | r2);
  endtask
endmodule

// [tb/test_pmic_system_status_regs.sv]
// Self-checking bench for the system configuration and status register bank
module test_pmic_system_status_regs import pss_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BTN_IRQ = 40;
  localparam int BTN_TO = 200;
  localparam int RST_UNIT = 8;
  localparam int WAKE = 4;
  logic clock = 1'b0, rst_n = 1'b0, pb_n = 1'b1, perf = 1'b0, uvlo = 1'b0;
  logic hib = 1'b0, frst = 1'b0, thermal_shutdown_flag = 1'b0, thermal_warning_flag = 1'b0;
  logic scl, sda_in, sda_out, sda_oe, irq_n, wake_n, hrst_n, long_press, perf_req, hyst;
  logic [1:0] fsd;
  pss_buck_in_s buck = '0;
  int err_total = 0, num_checks = 0, wake_cnt = 0;
  // Device under test with shortened counts
  pss_regs #(.BTN_IRQ_CYCLES(BTN_IRQ), .BTN_TO_CYCLES(BTN_TO), .RST_UNIT_CYCLES(RST_UNIT),
    .WAKE_CYCLES(WAKE)) pss_regs_inst (.clock(clock), .rst_n(rst_n), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .push_button_in_n(pb_n),
    .high_performance_mode(perf), .supply_undervoltage_lockout(uvlo), .hibernate_mode(hib),
    .fault_restart(frst), .thermal_shutdown_cond(thermal_shutdown_flag), .thermal_warning_cond(thermal_warning_flag),
    .buck_in(buck), .irq_out_low_n(irq_n), .wake_pulse_out_n(wake_n),
    .host_reset_out_n(hrst_n), .button_long_press(long_press), .perf_mode_request(perf_req),
    .freq_displacement_sel(fsd), .first_buck_hysteretic_active(hyst));
  // Host controller model on the serial pins
  pss_i2c_host pss_i2c_host_inst (.clock(clock), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl(scl), .sda_in(sda_in));
  // 25 MHz clock
  initial forever #20 clock = ~clock;
  // Counts cycles of the wake pulse, sampled away from the edge that moves it
  always @(negedge clock) if (wake_n === 1'b0) wake_cnt <= wake_cnt + 1;
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    pss_i2c_host_inst.write_reg(BUS_ADDR_DEFAULT, a, d, ok);
    chk({7'h0, ok}, 8'h01);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    pss_i2c_host_inst.read_reg(a, d, ok);
    chk({7'h0, ok}, 8'h01);
    chk(d, exp);
  endtask
  // Short pulse on one live buck input bit
  task automatic zap(input int k);
    buck[k] = 1'b1;
    cyc(4);
    buck[k] = 1'b0;
    cyc(4);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // Live part of the first buck status byte
  function automatic logic [7:0] live(input pss_buck_in_s b);
    return {5'h0, b.enabled & b.ss_done, b.pgood, b.enabled};
  endfunction
  task automatic final_report();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge clock);
    err_total++;
    final_report();
  end
  initial begin
    logic [7:0] v, f;
    logic ok;
    int n;
    void'($urandom(88771));
    cyc(4);
    rst_n = 1'b1;
    n = 0;
    while (hrst_n !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    chk({7'h0, n >= 16 * RST_UNIT - 2 && n <= 16 * RST_UNIT + 6}, 8'h01);
    if (n >= 400) final_report();
    rd(OFS_BUS_ADDRESS, 8'hdb);
    rd(OFS_CHIP_IDENTITY, {DEVICE_IDENT_DEFAULT, REVISION_DEFAULT});
    rd(OFS_SYSTEM_TIMING, 8'h54);
    rd(OFS_SYSTEM_CONFIG, 8'hc0);
    rd(OFS_SYSTEM_EVENT_STATUS, 8'h00);
    rd(8'h0a, 8'h00);
    v = 8'($urandom);
    wr(OFS_BUS_ADDRESS, v);
    rd(OFS_BUS_ADDRESS, 8'hdb);
    wr(OFS_CHIP_IDENTITY, v);
    rd(OFS_CHIP_IDENTITY, {DEVICE_IDENT_DEFAULT, REVISION_DEFAULT});
    pss_i2c_host_inst.write_reg(7'h5a, OFS_SYSTEM_CONFIG, 8'h00, ok);
    chk({7'h0, ok}, 8'h00);
    rd(OFS_SYSTEM_CONFIG, 8'hc0);
    done("reset and identity");
    // Thermal shutdown then thermal warning: masking, latching, clear on read
    for (int k = 0; k < 2; k++) begin
      f = 8'h80 >> k;
      {thermal_shutdown_flag, thermal_warning_flag} = 2'b10 >> k;
      cyc(10);
      chk({7'h0, irq_n}, 8'h01);
      wr(OFS_SYSTEM_CONFIG, 8'hc0 & ~f);
      chk({7'h0, irq_n}, 8'h00);
      rd(OFS_SYSTEM_EVENT_STATUS, f);
      rd(OFS_SYSTEM_EVENT_STATUS, f);
      {thermal_shutdown_flag, thermal_warning_flag} = 2'b00;
      cyc(5);
      rd(OFS_SYSTEM_EVENT_STATUS, f);
      rd(OFS_SYSTEM_EVENT_STATUS, 8'h00);
      chk({7'h0, irq_n}, 8'h01);
      wr(OFS_SYSTEM_CONFIG, 8'hc0);
    end
    done("thermal flags");
    pb_n = 1'b0;
    cyc(BTN_IRQ - 10);
    chk({7'h0, irq_n}, 8'h01);
    cyc(20);
    chk({7'h0, irq_n}, 8'h00);
    chk({7'h0, long_press}, 8'h00);
    cyc(BTN_TO - BTN_IRQ);
    chk({7'h0, long_press}, 8'h01);
    pb_n = 1'b1;
    cyc(5);
    rd(OFS_SYSTEM_EVENT_STATUS, 8'h20);
    rd(OFS_SYSTEM_EVENT_STATUS, 8'h00);
    chk({7'h0, irq_n}, 8'h01);
    done("push button");
    // Configuration corners and random values, then undervoltage
    perf = 1'b1;
    buck.automatic_pulse_freq_mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      wr(OFS_SYSTEM_CONFIG, v);
      rd(OFS_SYSTEM_CONFIG, v);
      chk({6'h0, fsd}, {6'h0, v[3:2]});
      chk({7'h0, perf_req}, {7'h0, v[5]});
      chk({7'h0, hyst}, {7'h0, v[1]});
      uvlo = 1'b1;
      cyc(5);
      uvlo = 1'b0;
      cyc(5);
      rd(OFS_SYSTEM_CONFIG, v & 8'hfe);
    end
    wr(OFS_SYSTEM_CONFIG, 8'hc0);
    done("configuration");
    buck = 7'b1110000;
    cyc(5);
    rd(OFS_FIRST_BUCK_STATUS, live(buck));
    zap(3);
    rd(OFS_FIRST_BUCK_STATUS, live(buck));
    zap(2);
    rd(OFS_FIRST_BUCK_STATUS, 8'h20 | live(buck));
    rd(OFS_FIRST_BUCK_STATUS, live(buck));
    zap(1);
    rd(OFS_FIRST_BUCK_STATUS, live(buck));
    buck.automatic_pulse_freq_mode = 1'b1;
    zap(1);
    rd(OFS_FIRST_BUCK_STATUS, 8'h10 | live(buck));
    buck.pgood = 1'b0;
    cyc(5);
    rd(OFS_FIRST_BUCK_STATUS, 8'h80 | live(buck));
    buck.pgood = 1'b1;
    cyc(5);
    rd(OFS_FIRST_BUCK_STATUS, 8'h80 | live(buck));
    rd(OFS_FIRST_BUCK_STATUS, live(buck));
    buck = 7'b0000000;
    zap(3);
    rd(OFS_FIRST_BUCK_STATUS, 8'hc0);
    rd(OFS_FIRST_BUCK_STATUS, 8'h00);
    done("buck status");
    hib = 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(OFS_SYSTEM_CONFIG, k ? 8'hd0 : 8'hc0);
      wake_cnt = 0;
      frst = 1'b1;
      cyc(20);
      frst = 1'b0;
      cyc(5);
      chk(8'(wake_cnt), k ? 8'h00 : 8'(WAKE));
    end
    done("wake pulse");
    v = 8'($urandom) | 8'h08;
    wr(OFS_SYSTEM_TIMING, v);
    rd(OFS_SYSTEM_TIMING, v & 8'hf7);
    wr(OFS_SYSTEM_EVENT_STATUS, 8'hff);
    rd(OFS_SYSTEM_EVENT_STATUS, 8'h00);
    done("timing and reserved");
    final_report();
  end
endmodule

// [verilog/pss_pkg.sv]
// Package: register map, field layout, reset values and timing constants
package pss_pkg;
  // Register offsets
  localparam logic [7:0] OFS_BUS_ADDRESS = 8'h00;
  localparam logic [7:0] OFS_CHIP_IDENTITY = 8'h01;
  localparam logic [7:0] OFS_SYSTEM_TIMING = 8'h02;
  localparam logic [7:0] OFS_SYSTEM_CONFIG = 8'h03;
  localparam logic [7:0] OFS_SYSTEM_EVENT_STATUS = 8'h04;
  localparam logic [7:0] OFS_FIRST_BUCK_STATUS = 8'h05;
  // Reset values and masks
  localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h5b;
  localparam logic BUS_ADDR_RSVD = 1'b1;
  localparam logic [7:0] TIMING_RESET = 8'h54;
  localparam logic [7:0] TIMING_WMASK = 8'hf7;
  localparam logic [7:0] CONFIG_RESET = 8'hc0;
  // Device and revision codes: arbitrary values
  localparam logic [3:0] DEVICE_IDENT_DEFAULT = 4'h1;
  localparam logic [3:0] REVISION_DEFAULT = 4'h0;
  // Configuration bit positions
  localparam int CFG_TSD_MASK = 7;
  localparam int CFG_TWR_MASK = 6;
  localparam int CFG_PERF_PIN_EN = 5;
  localparam int CFG_WAKE_DIS = 4;
  localparam int CFG_HYST_EN = 1;
  localparam int CFG_USER = 0;
  // Timing field positions
  localparam int TMG_BTN_TO_LSB = 6;
  localparam int TMG_BTN_IRQ_LSB = 4;
  localparam int TMG_RST_DLY_LSB = 0;
  // I2C framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Timing figures and their cycle counts
  localparam longint CLK_HZ = 25000000;
  localparam longint BTN_IRQ_MS = 500;
  localparam longint BTN_TO_MS = 4000;
  localparam longint RST_DLY_MS = 16;
  localparam longint RST_DLY_CODE_SHIFT = 4;
  localparam longint WAKE_PULSE_US = 10;
  localparam int BTN_IRQ_CYC = int'(CLK_HZ / 1000 * BTN_IRQ_MS);
  localparam int BTN_TO_CYC = int'(CLK_HZ / 1000 * BTN_TO_MS);
  localparam int RST_UNIT_CYC = int'(CLK_HZ / 1000 * RST_DLY_MS >> RST_DLY_CODE_SHIFT);
  localparam int WAKE_CYC = int'(CLK_HZ / 1000000 * WAKE_PULSE_US);
  // I2C engine states, Gray along the usual path
  typedef enum logic [2:0] {
    PSS_IDLE = 3'h0,
    PSS_ADDR = 3'h1,
    PSS_PTR = 3'h3,
    PSS_WR = 3'h2,
    PSS_RD = 3'h6
  } pss_phase_e;
  // Live first buck channel inputs
  typedef struct packed {
    logic enabled;
    logic ss_done;
    logic pgood;
    logic oc_eoc;
    logic neg_limit;
    logic zc_trip;
    logic automatic_pulse_freq_mode;
  } pss_buck_in_s;
  // Synchroniser vector layout
  typedef struct packed {
    logic scl;
    logic sda;
    logic button_n;
    logic perf_pin;
    logic uvlo;
    logic hibernate;
    logic fault_restart;
    logic tsd_cond;
    logic twr_cond;
    pss_buck_in_s buck;
  } pss_pins_s;
endpackage

// [verilog/pss_regs.sv]
// System configuration and status register bank behind an I2C target
// Function
// - Seven-bit bus address sits read-only in bits 6..0, default 0x5B.
// - Bit 7 of the address register always reads one.
// - Identity register: device code bits 7..4, revision bits 3..0, read-only.
// - Timing bits 7..6 pick the button time-out; reset code 01 is 4 s.
// - Timing bits 5..4 pick button interrupt delay; reset code 01 is 0.5 s.
// - Timing bits 2..0 pick host reset release delay; reset code 100 is 16 ms.
// - Thermal shutdown flag pulls interrupt low only while its mask is zero.
// - Thermal warning flag pulls interrupt low only while its mask is zero.
// - Performance mode pin is ignored until software sets its enable bit.
// - Disable bit suppresses wake pulse before automatic restart in hibernate.
// - Configuration bits 3..2 select frequency displacement, reset zero.
// - Hysteretic bit runs first buck hysteretic while in automatic PFM.
// - Configuration bit 0 is user storage, cleared by supply undervoltage.
// - Shutdown flag latches; read clears it only once condition has gone.
// - Warning flag latches; read clears it only once condition has gone.
// - Button flag sets at interrupt delay; read clears it and restarts counter.
// - Fault flag latches on hiccup, or enabled, soft-started and power-good low.
// - Hiccup flag latches when overcurrent end count arrives with power-good low.
// - Negative limit flag latches when negative limit threshold is reached.
// - Zero-crossing flag sets when comparator trips during automatic PFM.
// - Soft-start-done and enable status bits are live, not latched.
// - Power-good status bit shows the comparator output live.
// - Reset-on-read bits clear once the host has read them.
module pss_regs import pss_pkg::*; #(
  parameter int BTN_IRQ_CYCLES = BTN_IRQ_CYC,
  parameter int BTN_TO_CYCLES = BTN_TO_CYC,
  parameter int RST_UNIT_CYCLES = RST_UNIT_CYC,
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic push_button_in_n,
  input wire logic high_performance_mode,
  input wire logic supply_undervoltage_lockout,
  input wire logic hibernate_mode,
  input wire logic fault_restart,
  input wire logic thermal_shutdown_cond,
  input wire logic thermal_warning_cond,
  input wire pss_buck_in_s buck_in,
  output logic irq_out_low_n,
  output logic wake_pulse_out_n,
  output logic host_reset_out_n,
  output logic button_long_press,
  output logic perf_mode_request,
  output logic [1:0] freq_displacement_sel,
  output logic first_buck_hysteretic_active
);

  typedef struct packed {
    pss_pins_s sync1;
    pss_pins_s sync2;
    logic scl_prev;
    logic sda_prev;
    pss_phase_e phase;
    logic ack;
    logic rw;
    logic nack;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] out;
    logic drv;
    logic [7:0] ptr;
    logic [7:0] timing;
    logic [7:0] system_config;
    logic tsd_flag;
    logic twr_flag;
    logic btn_flag;
    logic [31:0] btn_cnt;
    logic long_press;
    logic [3:0] buck_flags;
    logic [31:0] rst_cnt;
    logic rst_done;
    logic fr_prev;
    logic [15:0] wake_cnt;
    logic wake_n;
  } pss_state_s;

  pss_state_s st_ff;
  pss_state_s nxt_st;
  pss_pins_s pins_raw;
  logic [7:0] rd_mux;
  logic [7:0] buck_status;
  logic irq_cause;
  logic [31:0] btn_irq_lim;
  logic [31:0] btn_to_lim;
  logic [31:0] rst_lim;

  assign pins_raw = '{scl: scl, sda: sda_in, button_n: push_button_in_n,
                      perf_pin: high_performance_mode, uvlo: supply_undervoltage_lockout,
                      hibernate: hibernate_mode, fault_restart: fault_restart,
                      tsd_cond: thermal_shutdown_cond, twr_cond: thermal_warning_cond,
                      buck: buck_in};

  // Status word of the first buck channel: latched flags high, live bits low
  assign buck_status = {st_ff.buck_flags, 1'b0,
                        st_ff.sync2.buck.enabled & st_ff.sync2.buck.ss_done,
                        st_ff.sync2.buck.pgood,
                        st_ff.sync2.buck.enabled};

  // Register read mux, unmapped offsets read zero
  always_comb begin
    unique case (st_ff.ptr)
      OFS_BUS_ADDRESS: rd_mux = {BUS_ADDR_RSVD, BUS_ADDR_DEFAULT};
      OFS_CHIP_IDENTITY: rd_mux = {DEVICE_IDENT_DEFAULT, REVISION_DEFAULT};
      OFS_SYSTEM_TIMING: rd_mux = st_ff.timing;
      OFS_SYSTEM_CONFIG: rd_mux = st_ff.system_config;
      OFS_SYSTEM_EVENT_STATUS: rd_mux = {st_ff.tsd_flag, st_ff.twr_flag, st_ff.btn_flag, 5'h00};
      OFS_FIRST_BUCK_STATUS: rd_mux = buck_status;
      default: rd_mux = 8'h00;
    endcase
  end

  // Selected delays; a code step doubles or halves the documented value
  assign btn_irq_lim = 32'((BTN_IRQ_CYCLES << st_ff.timing[TMG_BTN_IRQ_LSB +: 2]) >> 1);
  assign btn_to_lim = 32'((BTN_TO_CYCLES << st_ff.timing[TMG_BTN_TO_LSB +: 2]) >> 1);
  assign rst_lim = 32'(RST_UNIT_CYCLES << st_ff.timing[TMG_RST_DLY_LSB +: 3]);

  // Next-state logic for the whole block
  always_comb begin
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic clr_sys;
    logic clr_buck;
    logic wr_en;
    logic btn_set;
    pss_buck_in_s b;
    scl_s = st_ff.sync2.scl;
    sda_s = st_ff.sync2.sda;
    scl_rise = scl_s & ~st_ff.scl_prev;
    scl_fall = ~scl_s & st_ff.scl_prev;
    start_c = scl_s & st_ff.scl_prev & st_ff.sda_prev & ~sda_s;
    stop_c = scl_s & st_ff.scl_prev & ~st_ff.sda_prev & sda_s;
    clr_sys = 1'b0;
    clr_buck = 1'b0;
    wr_en = 1'b0;
    btn_set = 1'b0;
    b = st_ff.sync2.buck;
    nxt_st = st_ff;
    nxt_st.sync1 = pins_raw;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.scl_prev = scl_s;
    nxt_st.sda_prev = sda_s;

    // I2C target engine
    if (start_c) begin
      nxt_st.phase = PSS_ADDR;
      nxt_st.bitcnt = 4'h0;
      nxt_st.ack = 1'b0;
      nxt_st.drv = 1'b0;
    end else if (stop_c) begin
      nxt_st.phase = PSS_IDLE;
      nxt_st.drv = 1'b0;
    end else if (st_ff.phase != PSS_IDLE) begin
      if (scl_rise && !st_ff.ack) begin
        nxt_st.shift = {st_ff.shift[6:0], sda_s};
        nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
      end else if (scl_rise && st_ff.phase == PSS_RD) begin
        nxt_st.nack = sda_s;
      end else if (scl_fall && !st_ff.ack && st_ff.bitcnt == BITS_PER_BYTE) begin
        nxt_st.ack = 1'b1;
        nxt_st.drv = 1'b1;
        unique case (st_ff.phase)
          PSS_ADDR: begin
            nxt_st.rw = st_ff.shift[0];
            if (st_ff.shift[7:1] != BUS_ADDR_DEFAULT) begin
              nxt_st.phase = PSS_IDLE;
              nxt_st.drv = 1'b0;
            end
          end
          PSS_PTR: nxt_st.ptr = st_ff.shift;
          PSS_WR: begin
            wr_en = 1'b1;
            nxt_st.ptr = st_ff.ptr + 8'h01;
          end
          default: nxt_st.drv = 1'b0;
        endcase
      end else if (scl_fall && st_ff.ack) begin
        nxt_st.ack = 1'b0;
        nxt_st.bitcnt = 4'h0;
        nxt_st.drv = 1'b0;
        if ((st_ff.phase == PSS_ADDR && st_ff.rw) || (st_ff.phase == PSS_RD && !st_ff.nack)) begin
          // Load the read byte; this is the moment it counts as read
          nxt_st.phase = PSS_RD;
          nxt_st.out = rd_mux;
          nxt_st.drv = ~rd_mux[7];
          nxt_st.ptr = st_ff.ptr + 8'h01;
          clr_sys = st_ff.ptr == OFS_SYSTEM_EVENT_STATUS;
          clr_buck = st_ff.ptr == OFS_FIRST_BUCK_STATUS;
        end else if (st_ff.phase == PSS_RD) begin
          nxt_st.phase = PSS_IDLE;
        end else if (st_ff.phase == PSS_ADDR) begin
          nxt_st.phase = PSS_PTR;
        end else begin
          nxt_st.phase = PSS_WR;
        end
      end else if (scl_fall && st_ff.phase == PSS_RD) begin
        nxt_st.out = {st_ff.out[6:0], 1'b0};
        nxt_st.drv = (st_ff.bitcnt == BITS_PER_BYTE) ? 1'b0 : ~st_ff.out[6];
      end
    end

    // Register writes; read-only offsets ignore them
    if (wr_en && st_ff.ptr == OFS_SYSTEM_TIMING) begin
      nxt_st.timing = st_ff.shift & TIMING_WMASK;
    end
    if (wr_en && st_ff.ptr == OFS_SYSTEM_CONFIG) begin
      nxt_st.system_config = st_ff.shift;
    end
    if (st_ff.sync2.uvlo) begin
      nxt_st.system_config[CFG_USER] = 1'b0;
    end

    // Thermal flags: a live condition keeps the flag set through a read
    nxt_st.tsd_flag = st_ff.sync2.tsd_cond | (st_ff.tsd_flag & ~clr_sys);
    nxt_st.twr_flag = st_ff.sync2.twr_cond | (st_ff.twr_flag & ~clr_sys);

    // Push-button hold counter; a read restarts it
    if (st_ff.sync2.button_n || clr_sys) begin
      nxt_st.btn_cnt = 32'h0;
    end else if (st_ff.btn_cnt < btn_to_lim) begin
      nxt_st.btn_cnt = st_ff.btn_cnt + 32'h1;
    end
    btn_set = !st_ff.sync2.button_n && st_ff.btn_cnt == btn_irq_lim;
    nxt_st.btn_flag = btn_set | (st_ff.btn_flag & ~clr_sys);
    nxt_st.long_press = !st_ff.sync2.button_n && st_ff.btn_cnt >= btn_to_lim;

    // First buck latched flags: fault, hiccup, negative limit, zero crossing
    nxt_st.buck_flags[2] = (b.oc_eoc & ~b.pgood) | (st_ff.buck_flags[2] & ~clr_buck);
    // Fault follows the new hiccup value, so one read clears both together
    nxt_st.buck_flags[3] = nxt_st.buck_flags[2] | (b.enabled & b.ss_done & ~b.pgood)
                           | (st_ff.buck_flags[3] & ~clr_buck);
    nxt_st.buck_flags[1] = b.neg_limit | (st_ff.buck_flags[1] & ~clr_buck);
    nxt_st.buck_flags[0] = (b.automatic_pulse_freq_mode & b.zc_trip) | (st_ff.buck_flags[0] & ~clr_buck);

    // Host reset release after the selected start-up delay
    if (!st_ff.rst_done) begin
      nxt_st.rst_cnt = st_ff.rst_cnt + 32'h1;
      nxt_st.rst_done = st_ff.rst_cnt + 32'h1 >= rst_lim;
    end

    // Wake pulse ahead of an automatic restart from hibernate
    nxt_st.fr_prev = st_ff.sync2.fault_restart;
    if (st_ff.wake_cnt != 16'h0) begin
      nxt_st.wake_cnt = st_ff.wake_cnt - 16'h1;
    end else if (st_ff.sync2.fault_restart && !st_ff.fr_prev && st_ff.sync2.hibernate
                 && !st_ff.system_config[CFG_WAKE_DIS]) begin
      nxt_st.wake_cnt = 16'(WAKE_CYCLES);
    end
    nxt_st.wake_n = nxt_st.wake_cnt == 16'h0;
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      // Synchronisers start at the pins' idle levels, so no false event follows reset
      st_ff.sync1.scl <= 1'b1;
      st_ff.sync1.sda <= 1'b1;
      st_ff.sync1.button_n <= 1'b1;
      st_ff.sync2.scl <= 1'b1;
      st_ff.sync2.sda <= 1'b1;
      st_ff.sync2.button_n <= 1'b1;
      st_ff.scl_prev <= 1'b1;
      st_ff.sda_prev <= 1'b1;
      st_ff.phase <= PSS_IDLE;
      st_ff.timing <= TIMING_RESET;
      st_ff.system_config <= CONFIG_RESET;
      st_ff.wake_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Pin drives
  assign irq_cause = (st_ff.tsd_flag & ~st_ff.system_config[CFG_TSD_MASK])
                     | (st_ff.twr_flag & ~st_ff.system_config[CFG_TWR_MASK])
                     | st_ff.btn_flag;
  assign irq_out_low_n = ~irq_cause;
  assign sda_out = 1'b0;
  assign sda_oe = st_ff.drv;
  assign wake_pulse_out_n = st_ff.wake_n;
  assign host_reset_out_n = st_ff.rst_done;
  assign button_long_press = st_ff.long_press;
  assign perf_mode_request = st_ff.sync2.perf_pin & st_ff.system_config[CFG_PERF_PIN_EN];
  assign freq_displacement_sel = st_ff.system_config[3:2];
  assign first_buck_hysteretic_active = st_ff.system_config[CFG_HYST_EN]
                                        & st_ff.sync2.buck.automatic_pulse_freq_mode;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic scl_fall_w;
  assign scl_fall_w = ~st_ff.sync2.scl & st_ff.scl_prev;

  sequence s_sys_read;
    st_ff.ack && scl_fall_w && st_ff.ptr == OFS_SYSTEM_EVENT_STATUS
      && ((st_ff.phase == PSS_ADDR && st_ff.rw) || (st_ff.phase == PSS_RD && !st_ff.nack));
  endsequence

  AST_TSD_IRQ: assert property (st_ff.tsd_flag && !st_ff.system_config[CFG_TSD_MASK] |-> !irq_out_low_n)
    else $error("unmasked shutdown flag did not pull interrupt low");
  AST_IRQ_CAUSE: assert property (!irq_out_low_n |-> st_ff.btn_flag
      || (st_ff.twr_flag && !st_ff.system_config[CFG_TWR_MASK])
      || (st_ff.tsd_flag && !st_ff.system_config[CFG_TSD_MASK]))
    else $error("interrupt low without an unmasked cause");
  AST_PERF_PIN: assert property (!st_ff.system_config[CFG_PERF_PIN_EN] |-> !perf_mode_request)
    else $error("performance pin acted while disabled");
  AST_USER_UVLO: assert property (st_ff.sync2.uvlo |=> !st_ff.system_config[CFG_USER])
    else $error("user bit survived undervoltage");
  // A read may clear the flag once the condition has gone, so it must stand two cycles
  AST_TSD_STICKY: assert property (st_ff.sync2.tsd_cond ##1 st_ff.sync2.tsd_cond
      |=> st_ff.tsd_flag [*2])
    else $error("shutdown flag lost while condition present");
  AST_BTN_READ: assert property (s_sys_read ##0 st_ff.sync2.button_n |=>
      !st_ff.btn_flag && st_ff.btn_cnt == 32'h0)
    else $error("button flag or counter not cleared by read");
  AST_FLT_HICCUP: assert property (st_ff.buck_flags[2] |-> st_ff.buck_flags[3])
    else $error("hiccup did not raise fault flag");
  AST_NEG_LATCH: assert property ($rose(st_ff.sync2.buck.neg_limit) |=> st_ff.buck_flags[1])
    else $error("negative limit flag not latched");
  AST_RSVD_ZERO: assert property (st_ff.timing[3] == 1'b0 && buck_status[3] == 1'b0)
    else $error("reserved bit read as one");
  AST_RST_HOLD: assert property (!st_ff.rst_done |-> st_ff.rst_cnt < rst_lim)
    else $error("host reset held past its delay");
endmodule
